// *** src/sslrp_pkg.sv ***
// Constants and types for the serial slave local RAM partition block.
// Assumes a single 200 MHz system clock; all host pins arrive asynchronously.
//
// Overview of operation
// R01: RAM of 256 bytes, usable only when enabled
// R02: Host and CPU exchange data only through RAM
// R03: Host sees a 128-byte offset space
// R04: Three areas, boundaries on 8-byte multiples
// R05: Direct area spans zero to FIFO start
// R06: Direct area mapped identically for host and CPU
// R07: Host read-only tail from read-only start segment
// R08: FIFO reached by host only at 0x7F
// R09: FIFO area spans FIFO start to end
// R10: FIFO end segment limited to 0x20 maximum
// R11: Private area above FIFO end, CPU only
// R12: RAM contents kept during deep sleep
// R13: Host operations served without CPU help
// R14: Watched host accesses raise an event
// R15: I2C own address of 7 or 10 bits
// R16: SPI works in all four clock modes
// R17: Host writes to read-only tail are dropped
// R18: Stream offset access keeps host offset fixed
// R19: Software keeps read-only start at 0x0A up
// R20: Software keeps segment fields in ascending order
package sslrp_pkg;
    localparam int RAM_BYTES = 256;
    localparam int RAM_AW = 8;
    localparam int RAM_DW = 8;
    localparam int HOST_AW = 7;
    localparam int HOST_BYTES = 128;
    localparam int SEG_W = 5;
    localparam int END_W = 6;
    localparam int SEG_SHIFT = 3;
    localparam int SYNC_W = 5;
    localparam int SPI_RW_BIT = 7;
    localparam logic [6:0] STREAM_OFFSET = 7'h7F;
    localparam logic [5:0] FIFO_END_MAX = 6'h20;
    localparam logic [4:0] RO_START_MIN = 5'h0A;
    localparam logic [4:0] I2C_HDR10 = 5'h1E;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    typedef enum logic [2:0] {I_IDLE, I_RX, I_ACK, I_ACKH, I_TX, I_TACK} sslrp_i2c_state_t;
    typedef enum logic [1:0] {K_HDR, K_ADR2, K_OFFS, K_DATA} sslrp_i2c_kind_t;
endpackage

// *** src/sslrp_ram.sv ***
// Two-port byte RAM shared by the CPU side and the host side.
// Assumes both ports run on the system clock; reads have one cycle latency.
`timescale 1ns/1ps
module sslrp_ram #(
    parameter int DEPTH = sslrp_pkg::RAM_BYTES,
    parameter int AW = sslrp_pkg::RAM_AW,
    parameter int DW = sslrp_pkg::RAM_DW
) (
    input wire logic clock_i,
    input wire logic a_en_i,
    input wire logic a_we_i,
    input wire logic [AW-1:0] a_addr_i,
    input wire logic [DW-1:0] a_wdata_i,
    output logic [DW-1:0] a_rdata_o,
    input wire logic b_en_i,
    input wire logic b_we_i,
    input wire logic [AW-1:0] b_addr_i,
    input wire logic [DW-1:0] b_wdata_i,
    output logic [DW-1:0] b_rdata_o
);
    import sslrp_pkg::*;

    // No reset on purpose: contents survive reset and sleep
    logic [DW-1:0] mem [DEPTH];

    // Port A is written last, so the CPU wins a same-address clash
    always_ff @(posedge clock_i) begin
        if (b_en_i && b_we_i) begin
            mem[b_addr_i] <= b_wdata_i;
        end
        if (a_en_i && a_we_i) begin
            mem[a_addr_i] <= a_wdata_i;
        end
    end

    // Registered read data on both ports
    always_ff @(posedge clock_i) begin
        if (a_en_i) begin
            a_rdata_o <= mem[a_addr_i];
        end
        if (b_en_i) begin
            b_rdata_o <= mem[b_addr_i];
        end
    end
endmodule

// *** src/sslrp_partition.sv ***
// Serial slave port: I2C/SPI host engines, area map and shared RAM.
// Assumes host pins are asynchronous and much slower than clock_i.
`timescale 1ns/1ps
module sslrp_partition (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic module_enable_i,
    input wire logic spi_select_i,
    input wire logic spi_cpol_i,
    input wire logic spi_cpha_i,
    input wire logic i2c_addr10_i,
    input wire logic [9:0] i2c_own_addr_i,
    input wire logic [sslrp_pkg::SEG_W-1:0] fifo_start_segment_field_i,
    input wire logic [sslrp_pkg::END_W-1:0] fifo_end_segment_field_i,
    input wire logic [sslrp_pkg::SEG_W-1:0] readonly_start_segment_i,
    input wire logic fifo_ptr_load_i,
    output logic [sslrp_pkg::RAM_AW-1:0] fifo_ptr_o,
    input wire logic [sslrp_pkg::HOST_BYTES-1:0] access_watch_i,
    output logic access_event_o,
    output logic [sslrp_pkg::HOST_AW-1:0] access_offset_o,
    output logic access_write_o,
    output logic cfg_order_error_o,
    input wire logic cpu_req_i,
    input wire logic cpu_write_i,
    input wire logic [sslrp_pkg::RAM_AW-1:0] cpu_addr_i,
    input wire logic [sslrp_pkg::RAM_DW-1:0] cpu_wdata_i,
    output logic [sslrp_pkg::RAM_DW-1:0] cpu_rdata_o,
    output logic cpu_ack_o,
    input wire logic spi_sck_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_n_o,
    input wire logic i2c_scl_i,
    input wire logic i2c_sda_i,
    output logic i2c_sda_o,
    output logic i2c_sda_oe_n_o
);
    import sslrp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge history
    logic [SYNC_W-1:0] pin_raw;
    logic [SYNC_W-1:0] sync_a;
    logic [SYNC_W-1:0] sync_b;
    logic [SYNC_W-1:0] sync_p;
    logic sck_b, cs_b, mosi_b, scl_b, sda_b;
    logic sck_p, cs_p, scl_p, sda_p;

    assign pin_raw = {spi_sck_i, spi_cs_n_i, spi_mosi_i, i2c_scl_i, i2c_sda_i};

    // Two stages before use; history taken from the second stage only
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            sync_a <= '1;
            sync_b <= '1;
            sync_p <= '1;
        end else begin
            sync_a <= pin_raw;
            sync_b <= sync_a;
            sync_p <= sync_b;
        end
    end

    assign {sck_b, cs_b, mosi_b, scl_b, sda_b} = sync_b;
    assign sck_p = sync_p[4];
    assign cs_p = sync_p[3];
    assign scl_p = sync_p[1];
    assign sda_p = sync_p[0];

    ////////////////////////////////////////////////////////////////////////////
    // Area boundaries
    logic [END_W-1:0] end_seg;
    logic [RAM_AW-1:0] fifo_base;
    logic [RAM_AW-1:0] ro_base;
    logic [RAM_AW:0] fifo_top;

    // Oversized end field is held at the top of RAM [R10]
    assign end_seg = (fifo_end_segment_field_i > FIFO_END_MAX) ? FIFO_END_MAX
                   : fifo_end_segment_field_i;
    // All boundaries are whole segments [R04]
    assign fifo_base = {fifo_start_segment_field_i, {SEG_SHIFT{1'b0}}}; // [R05]
    assign ro_base = {readonly_start_segment_i, {SEG_SHIFT{1'b0}}};
    assign fifo_top = {end_seg, {SEG_SHIFT{1'b0}}}; // [R09] [R11]

    // Flag a misordered configuration for software
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            cfg_order_error_o <= 1'b0;
        end else begin
            cfg_order_error_o <= (readonly_start_segment_i > fifo_start_segment_field_i)
                || ({1'b0, fifo_start_segment_field_i} > end_seg)
                || (fifo_end_segment_field_i > FIFO_END_MAX); // [R20]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Engine events, muxed by interface selection
    logic spi_on, i2c_on;
    logic spi_ev_offs, spi_ev_wr, spi_ev_rd, spi_ev_rstart;
    logic i2c_ev_offs, i2c_ev_wr, i2c_ev_rd, i2c_ev_rstart;
    logic [7:0] spi_byte, i2c_byte;
    logic ev_offs, ev_wr, ev_rd, ev_rstart;
    logic [7:0] ev_byte;

    assign spi_on = module_enable_i && spi_select_i; // [R01]
    assign i2c_on = module_enable_i && !spi_select_i;
    assign ev_offs = spi_select_i ? spi_ev_offs : i2c_ev_offs;
    assign ev_wr = spi_select_i ? spi_ev_wr : i2c_ev_wr;
    assign ev_rd = spi_select_i ? spi_ev_rd : i2c_ev_rd;
    assign ev_rstart = spi_select_i ? spi_ev_rstart : i2c_ev_rstart;
    assign ev_byte = spi_select_i ? spi_byte : i2c_byte;

    ////////////////////////////////////////////////////////////////////////////
    // Host offset, FIFO pointer and host-side map
    logic [HOST_AW-1:0] host_offset;
    logic [RAM_AW-1:0] fifo_ptr;
    logic [RAM_AW-1:0] next_fifo_ptr;
    logic stream, direct, writable, readable, fifo_ptr_ok;
    logic [RAM_AW-1:0] host_ram_addr;

    assign stream = (host_offset == STREAM_OFFSET);
    assign direct = ({1'b0, host_offset} < fifo_base) && !stream; // [R05]
    assign writable = direct && ({1'b0, host_offset} < ro_base); // [R07] [R17]
    assign fifo_ptr_ok = (fifo_ptr >= fifo_base) && ({1'b0, fifo_ptr} < fifo_top);
    assign readable = direct || (stream && fifo_ptr_ok); // [R08]
    // Direct bytes keep their offset; the stream offset follows the pointer
    assign host_ram_addr = stream ? fifo_ptr : {1'b0, host_offset}; // [R06] [R08]

    // Step within the FIFO area, wrapping at its top
    always_comb begin
        if (!fifo_ptr_ok || ({1'b0, fifo_ptr} + 9'h001 >= fifo_top)) begin
            next_fifo_ptr = fifo_base; // [R09]
        end else begin
            next_fifo_ptr = fifo_ptr + 8'h01;
        end
    end

    // Offset advances per byte, except at the streaming port
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            host_offset <= '0;
        end else if (ev_offs) begin
            host_offset <= ev_byte[HOST_AW-1:0]; // [R03]
        end else if ((ev_wr || ev_rd) && !stream) begin
            host_offset <= host_offset + 7'h01;
        end // [R18]
    end

    // Pointer reloads to the FIFO base on request, otherwise moves only when a streamed byte has gone out
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            fifo_ptr <= '0;
        end else if (fifo_ptr_load_i) begin
            fifo_ptr <= fifo_base;
        end else if (ev_rd && stream) begin
            fifo_ptr <= next_fifo_ptr; // [R09]
        end
    end

    assign fifo_ptr_o = fifo_ptr;

    ////////////////////////////////////////////////////////////////////////////
    // Shared RAM; the only path between CPU and host [R02]
    logic ram_a_en, ram_a_we, ram_b_en, ram_b_we;
    logic [RAM_DW-1:0] ram_b_q;
    logic [RAM_AW-1:0] ram_b_addr;
    logic fetch_req, fetch_d, fetch_ok_d;
    logic [7:0] rd_byte;

    assign ram_a_en = cpu_req_i && module_enable_i; // [R01]
    assign ram_a_we = ram_a_en && cpu_write_i;
    // Host writes outside the writable span never reach the RAM [R17]
    assign ram_b_we = module_enable_i && ev_wr && writable;
    assign ram_b_en = module_enable_i && ((fetch_req && readable) || ram_b_we); // [R11]
    assign ram_b_addr = host_ram_addr;

    // Contents have no reset, so they persist through sleep [R12]
    sslrp_ram #(
        .DEPTH(RAM_BYTES),
        .AW(RAM_AW),
        .DW(RAM_DW)
    ) u_ram (
        .clock_i(clock_i),
        .a_en_i(ram_a_en),
        .a_we_i(ram_a_we),
        .a_addr_i(cpu_addr_i),
        .a_wdata_i(cpu_wdata_i),
        .a_rdata_o(cpu_rdata_o),
        .b_en_i(ram_b_en),
        .b_we_i(ram_b_we),
        .b_addr_i(ram_b_addr),
        .b_wdata_i(ev_byte),
        .b_rdata_o(ram_b_q)
    );

    // CPU access answered one cycle after the request
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            cpu_ack_o <= 1'b0;
        end else begin
            cpu_ack_o <= ram_a_en; // [R02]
        end
    end

    // Fetch one cycle after the event so offset and pointer have settled
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            fetch_req <= 1'b0;
            fetch_d <= 1'b0;
            fetch_ok_d <= 1'b0;
            rd_byte <= UNMAPPED_READ;
        end else begin
            fetch_req <= ev_rd || ev_rstart;
            fetch_d <= fetch_req;
            fetch_ok_d <= fetch_req && readable;
            if (fetch_d) begin
                rd_byte <= fetch_ok_d ? ram_b_q : UNMAPPED_READ;
            end
        end
    end

    // Watched offsets raise a pulse for the CPU, no CPU needed to serve [R13]
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            access_event_o <= 1'b0;
            access_offset_o <= '0;
            access_write_o <= 1'b0;
        end else begin
            access_event_o <= (ev_wr || ev_rd) && access_watch_i[host_offset]; // [R14]
            if (ev_wr || ev_rd) begin
                access_offset_o <= host_offset;
                access_write_o <= ev_wr;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // SPI engine; first byte is {write, offset}
    logic [2:0] spi_cnt;
    logic [6:0] spi_sh;
    logic spi_first, spi_rw, spi_act;
    logic sck_k, sck_kp, lead, trail, samp, shft, spi_done;

    // Normalise polarity, then pick the sampling edge by phase [R16]
    assign sck_k = sck_b ^ spi_cpol_i;
    assign sck_kp = sck_p ^ spi_cpol_i;
    assign lead = sck_k && !sck_kp;
    assign trail = !sck_k && sck_kp;
    assign samp = spi_cpha_i ? trail : lead;
    assign shft = spi_cpha_i ? lead : trail;
    assign spi_act = spi_on && !cs_b;
    assign spi_done = spi_act && samp && (spi_cnt == LAST_BIT);
    assign spi_byte = {spi_sh, mosi_b};
    assign spi_ev_offs = spi_done && spi_first;
    assign spi_ev_rstart = spi_ev_offs && !spi_byte[SPI_RW_BIT];
    assign spi_ev_wr = spi_done && !spi_first && spi_rw;
    assign spi_ev_rd = spi_done && !spi_first && !spi_rw;

    // Shifter; data is launched on the edge opposite the sampling one
    always_ff @(posedge clock_i) begin
        if (reset_i || !spi_act) begin
            spi_cnt <= '0;
            spi_sh <= '0;
            spi_first <= 1'b1;
            spi_rw <= 1'b0;
            spi_miso_o <= 1'b0;
            spi_miso_oe_n_o <= 1'b1;
        end else begin
            spi_miso_oe_n_o <= 1'b0;
            if (samp) begin
                spi_sh <= spi_byte[6:0];
                spi_cnt <= spi_cnt + 3'h1;
                if (spi_done && spi_first) begin
                    spi_first <= 1'b0;
                    spi_rw <= spi_byte[SPI_RW_BIT];
                end
            end
            if (shft) begin
                spi_miso_o <= (spi_first || spi_rw) ? 1'b0 : rd_byte[LAST_BIT - spi_cnt];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // I2C engine; write carries offset then data, read streams from offset
    sslrp_i2c_state_t i2c_st;
    sslrp_i2c_kind_t i2c_kind;
    logic [2:0] i2c_cnt;
    logic [6:0] i2c_sh;
    logic ack_ok, to_read, a10_ok;
    logic scl_rise, scl_fall, start_c, stop_c, i2c_done, hdr_ok, byte_ok;

    assign scl_rise = scl_b && !scl_p;
    assign scl_fall = !scl_b && scl_p;
    assign start_c = scl_b && scl_p && sda_p && !sda_b;
    assign stop_c = scl_b && scl_p && !sda_p && sda_b;
    assign i2c_byte = {i2c_sh, sda_b};
    assign i2c_done = i2c_on && (i2c_st == I_RX) && scl_rise && (i2c_cnt == LAST_BIT);

    // Own address match; a 10-bit read needs the earlier full match [R15]
    always_comb begin
        if (i2c_addr10_i) begin
            hdr_ok = (i2c_byte[7:3] == I2C_HDR10) && (i2c_byte[2:1] == i2c_own_addr_i[9:8])
                  && (!i2c_byte[0] || a10_ok);
        end else begin
            hdr_ok = (i2c_byte[7:1] == i2c_own_addr_i[6:0]);
        end
        case (i2c_kind)
            K_HDR: byte_ok = hdr_ok;
            K_ADR2: byte_ok = (i2c_byte == i2c_own_addr_i[7:0]);
            default: byte_ok = 1'b1;
        endcase
    end

    assign i2c_ev_offs = i2c_done && (i2c_kind == K_OFFS);
    assign i2c_ev_wr = i2c_done && (i2c_kind == K_DATA);
    assign i2c_ev_rstart = i2c_done && (i2c_kind == K_HDR) && hdr_ok && i2c_byte[0];
    assign i2c_ev_rd = i2c_on && (i2c_st == I_TACK) && scl_rise;
    assign i2c_sda_o = 1'b0;

    // Bit engine; drives only low, releasing while SCL is low
    always_ff @(posedge clock_i) begin
        if (reset_i || !i2c_on) begin
            i2c_st <= I_IDLE;
            i2c_kind <= K_HDR;
            i2c_cnt <= '0;
            i2c_sh <= '0;
            ack_ok <= 1'b0;
            to_read <= 1'b0;
            a10_ok <= 1'b0;
            i2c_sda_oe_n_o <= 1'b1;
        end else if (start_c) begin
            i2c_st <= I_RX;
            i2c_kind <= K_HDR;
            i2c_cnt <= '0;
            i2c_sda_oe_n_o <= 1'b1;
        end else if (stop_c) begin
            i2c_st <= I_IDLE;
            a10_ok <= 1'b0;
            i2c_sda_oe_n_o <= 1'b1;
        end else begin
            case (i2c_st)
                I_IDLE: begin
                    i2c_sda_oe_n_o <= 1'b1;
                end
                I_RX: if (scl_rise) begin
                    i2c_sh <= i2c_byte[6:0];
                    i2c_cnt <= i2c_cnt + 3'h1;
                    if (i2c_cnt == LAST_BIT) begin
                        ack_ok <= byte_ok;
                        to_read <= (i2c_kind == K_HDR) && i2c_byte[0];
                        i2c_st <= I_ACK;
                        case (i2c_kind)
                            K_HDR: i2c_kind <= (i2c_addr10_i && !i2c_byte[0]) ? K_ADR2 : K_OFFS;
                            K_ADR2: begin
                                i2c_kind <= K_OFFS;
                                a10_ok <= byte_ok;
                            end
                            default: i2c_kind <= K_DATA;
                        endcase
                    end
                end
                I_ACK: if (scl_fall) begin
                    i2c_sda_oe_n_o <= !ack_ok; // [R15]
                    i2c_st <= ack_ok ? I_ACKH : I_IDLE;
                end
                I_ACKH: if (scl_fall) begin
                    i2c_cnt <= '0;
                    i2c_st <= to_read ? I_TX : I_RX;
                    i2c_sda_oe_n_o <= to_read ? rd_byte[LAST_BIT] : 1'b1;
                end
                I_TX: begin
                    if (scl_rise) begin
                        i2c_cnt <= i2c_cnt + 3'h1;
                        if (i2c_cnt == LAST_BIT) begin
                            i2c_st <= I_TACK;
                        end
                    end
                    if (scl_fall) begin
                        i2c_sda_oe_n_o <= rd_byte[LAST_BIT - i2c_cnt];
                    end
                end
                I_TACK: begin
                    if (scl_fall) begin
                        i2c_sda_oe_n_o <= 1'b1;
                    end
                    if (scl_rise) begin
                        i2c_st <= sda_b ? I_IDLE : I_ACKH;
                    end
                end
                default: i2c_st <= I_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_disabled_quiet;
        @(posedge clock_i) disable iff (reset_i)
        !module_enable_i |-> !ram_a_en && !ram_b_en;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) // [R01]
        else $error("RAM touched while disabled");

    property p_cpu_ack;
        @(posedge clock_i) disable iff (reset_i)
        (cpu_req_i && module_enable_i) |=> cpu_ack_o;
    endproperty
    a_cpu_ack: assert property (p_cpu_ack) // [R02]
        else $error("CPU access not answered");

    property p_offset_step;
        @(posedge clock_i) disable iff (reset_i)
        (ev_wr || ev_rd) && !stream |=> host_offset == $past(host_offset) + 7'h01;
    endproperty
    a_offset_step: assert property (p_offset_step) // [R03]
        else $error("Host offset did not step by one");

    property p_stream_hold;
        @(posedge clock_i) disable iff (reset_i)
        (ev_wr || ev_rd) && stream |=> stream [*2];
    endproperty
    a_stream_hold: assert property (p_stream_hold) // [R18]
        else $error("Stream offset moved");

    property p_ro_protect;
        @(posedge clock_i) disable iff (reset_i)
        ram_b_we |-> (ram_b_addr < ro_base) && (ram_b_addr < fifo_base);
    endproperty
    a_ro_protect: assert property (p_ro_protect) // [R07] [R17]
        else $error("Host wrote read-only or non-direct byte");

    property p_no_private;
        @(posedge clock_i) disable iff (reset_i)
        ram_b_en |-> ({1'b0, ram_b_addr} < fifo_top);
    endproperty
    a_no_private: assert property (p_no_private) // [R11]
        else $error("Host reached private area");

    property p_direct_identity;
        @(posedge clock_i) disable iff (reset_i)
        ram_b_en && !stream |-> ram_b_addr == {1'b0, host_offset};
    endproperty
    a_direct_identity: assert property (p_direct_identity) // [R06]
        else $error("Direct offset not mapped one to one");

    property p_fifo_wrap;
        @(posedge clock_i) disable iff (reset_i)
        ev_rd && stream && fifo_ptr_ok && !fifo_ptr_load_i
            && ({1'b0, fifo_ptr} + 9'h001 == fifo_top) |=> fifo_ptr == $past(fifo_base);
    endproperty
    a_fifo_wrap: assert property (p_fifo_wrap) // [R09]
        else $error("FIFO pointer did not wrap to base");

    property p_spi_release;
        @(posedge clock_i) disable iff (reset_i)
        !spi_act |=> spi_miso_oe_n_o;
    endproperty
    a_spi_release: assert property (p_spi_release) // [R16]
        else $error("MISO driven while deselected");

    property p_i2c_drive;
        @(posedge clock_i) disable iff (reset_i)
        !i2c_sda_oe_n_o |-> i2c_st inside {I_ACKH, I_TX, I_TACK};
    endproperty
    a_i2c_drive: assert property (p_i2c_drive) // [R15]
        else $error("SDA driven outside ack or read");
endmodule

// *** testbench/sslrp_spi_host.sv ***
// Behavioural SPI host driving the serial slave port, polarity from cpol_i, phase 0.
// Assumes the testbench calls its tasks; link clock period is 125 ns.
`timescale 1ns/1ps
module sslrp_spi_host (
    input wire logic cpol_i,
    output logic sck_o,
    output logic cs_n_o,
    output logic mosi_o,
    input wire logic miso_i,
    input wire logic miso_oe_n_i
);
    ////////////////////////////////////////////////////////////////////////////
    // Idle: clock parked low, select released
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // One byte, MSB first, sampled on the leading edge
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi_o = tx[i];
            #62.5 sck_o = ~cpol_i;
            rx[i] = miso_oe_n_i ? ~miso_i : miso_i; // Undriven line never matches
            #62.5 sck_o = cpol_i;
        end
    endtask
    // Whole frame; a stale MOSI is inverted so nothing relies on it
    task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
                         output logic [7:0] r1, output logic [7:0] r2);
        logic [7:0] r0;
        sck_o = cpol_i; // Park at idle level while still deselected
        #125 cs_n_o = 1'b0;
        #125 xfer(b0, r0);
        xfer(b1, r1);
        xfer(b2, r2);
        #125 cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        #250;
    endtask
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the local RAM partition block.
// Assumes the SPI host model; I2C pins idle high, host offset 5 watched.
`timescale 1ns/1ps
module testbench;
    import sslrp_pkg::*;
    logic clock_i = 1'b0, reset_i = 1'b1, en = 1'b0, sel = 1'b1, load = 1'b0;
    logic cpol = 1'b0, ev, acc_wr, cfg_err;
    logic [6:0] acc_off;
    logic [127:0] watch = 128'h20;
    logic req = 1'b0, wr = 1'b0, ack, sck, cs_n, mosi, miso, miso_oe_n;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, ptr, r1, r2, r;
    logic [4:0] fstart = 5'h10, ro = 5'h0A; // Ascending, read-only from 0x50
    logic [5:0] fend = 6'h11; // Eight FIFO bytes, so a short stream wraps
    int bad_count = 0, checks = 0, hits = 0;
    always #2.5 clock_i = ~clock_i;
    // Event pulses counted on the settled edge
    always @(negedge clock_i) begin
        if (ev) hits++;
    end
    ////////////////////////////////////////////////////////////////////////////
    sslrp_partition dut (.clock_i(clock_i), .reset_i(reset_i), .module_enable_i(en),
        .spi_select_i(sel), .spi_cpol_i(cpol), .spi_cpha_i(1'b0), .i2c_addr10_i(1'b0),
        .i2c_own_addr_i(10'h000), .fifo_start_segment_field_i(fstart),
        .fifo_end_segment_field_i(fend), .readonly_start_segment_i(ro),
        .fifo_ptr_load_i(load), .fifo_ptr_o(ptr), .access_watch_i(watch), .access_event_o(ev),
        .access_offset_o(acc_off), .access_write_o(acc_wr),
        .cfg_order_error_o(cfg_err), .cpu_req_i(req),
        .cpu_write_i(wr), .cpu_addr_i(addr), .cpu_wdata_i(wdata), .cpu_rdata_o(rdata),
        .cpu_ack_o(ack), .spi_sck_i(sck), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi),
        .spi_miso_o(miso), .spi_miso_oe_n_o(miso_oe_n), .i2c_scl_i(1'b1),
        .i2c_sda_i(1'b1), .i2c_sda_o(), .i2c_sda_oe_n_o());
    sslrp_spi_host host (.cpol_i(cpol), .sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi),
        .miso_i(miso), .miso_oe_n_i(miso_oe_n));
    ////////////////////////////////////////////////////////////////////////////
    // Comparison and verdict
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic stop_test();
        if (bad_count == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // One CPU access; ack must follow exactly one cycle later
    task automatic cpu(input logic w, input logic [7:0] a, input logic [7:0] d,
                       input logic [7:0] exp);
        @(negedge clock_i);
        {req, wr, addr, wdata} = {1'b1, w, a, d};
        @(negedge clock_i);
        req = 1'b0;
        check("cpu_ack", {7'h00, ack}, {7'h00, en});
        if (!w && en) check("cpu_rdata", rdata, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Private area reached by CPU; disabled block ignores requests
    task automatic t_cpu();
        cpu(1'b1, 8'hF0, 8'h5A, 8'h00);
        cpu(1'b0, 8'hF0, 8'h00, 8'h5A);
        en = 1'b0;
        cpu(1'b0, 8'hF0, 8'h00, 8'h00);
        en = 1'b1;
    endtask
    // Host burst write into direct area, seen by CPU at same address
    task automatic t_direct();
        host.frame(8'h85, 8'hAA, 8'hBB, r1, r2);
        cpu(1'b0, 8'h05, 8'h00, 8'hAA);
        cpu(1'b0, 8'h06, 8'h00, 8'hBB);
        cpol = 1'b1; // Read back with the clock idling high
        host.frame(8'h05, 8'h00, 8'h00, r1, r2);
        @(negedge clock_i) cpol = 1'b0;
        check("spi_rd0", r1, 8'hAA);
        check("spi_rd1", r2, 8'hBB);
        check("watch_hits", hits[7:0], 8'h02);
    endtask
    // Host writes into the read-only tail leave RAM alone
    task automatic t_readonly();
        cpu(1'b1, 8'h50, 8'h11, 8'h00);
        cpu(1'b1, 8'h4F, 8'h22, 8'h00);
        host.frame(8'hCF, 8'h33, 8'h99, r1, r2);
        cpu(1'b0, 8'h4F, 8'h00, 8'h33);
        cpu(1'b0, 8'h50, 8'h00, 8'h11);
        check("acc_offset", {1'b0, acc_off}, 8'h50);
        check("acc_write", {7'h00, acc_wr}, 8'h01);
    endtask
    // Stream offset returns successive FIFO bytes without stepping
    task automatic t_fifo();
        cpu(1'b1, 8'h80, 8'hC1, 8'h00);
        cpu(1'b1, 8'h81, 8'hC2, 8'h00);
        @(negedge clock_i) load = 1'b1;
        @(negedge clock_i) load = 1'b0;
        check("fifo_ptr", ptr, 8'h80);
        host.frame(8'h7F, 8'h00, 8'h00, r1, r2);
        check("fifo_rd0", r1, 8'hC1);
        check("fifo_rd1", r2, 8'hC2);
        check("fifo_ptr_adv", ptr, 8'h82);
        repeat (3) host.frame(8'h7F, 8'h00, 8'h00, r1, r2);
        check("fifo_wrap", ptr, 8'h80);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        repeat (6) @(negedge clock_i);
        reset_i = 1'b0;
        en = 1'b1;
        repeat (4) @(negedge clock_i);
        t_cpu();
        t_direct();
        t_readonly();
        t_fifo();
        check("cfg_order", {7'h00, cfg_err}, 8'h00);
        stop_test();
    end
    initial begin
        #100000;
        bad_count++;
        stop_test();
    end
endmodule
